// [verification/ram_port_user.sv]
// Behavioural user logic for one memory port: frames the port and pipe clock pins.
// Assumes mclk_i is the memory's system clock; clock and control pins stay low between frames, address and data lines are inverted.
`timescale 1ns/1ps

module ram_port_user (
  input  wire logic        mclk_i,
  output logic             clk_o,
  output logic             pipe_clk_o,
  output logic             en_o,
  output logic [3:0]       we_o,
  output logic [12:0]      addr_o,
  output logic [31:0]      word_o,
  output logic [3:0]       chk_o,
  output logic             preset_o,
  output logic             hold_o
);
  initial
  begin
    {clk_o, pipe_clk_o, en_o, we_o, addr_o, word_o, chk_o, preset_o, hold_o} = '0;
  end

  // Request held over the whole high phase: the sampled tick comes 2-3 mclk late
  task automatic access(input logic en, input logic [3:0] we, input logic [12:0] addr,
                        input logic [35:0] d, input logic pr);
    begin
      @(posedge mclk_i);
      clk_o           <= 1'b1;
      en_o            <= en;
      we_o            <= we;
      addr_o          <= addr;
      {chk_o, word_o} <= d;
      preset_o        <= pr;
      repeat (4) @(posedge mclk_i);
      clk_o           <= 1'b0;
      en_o            <= 1'b0;
      we_o            <= 4'h0;
      addr_o          <= ~addr;
      {chk_o, word_o} <= ~d;  // Released lines do not keep the last value
      preset_o        <= 1'b0;
      repeat (4) @(posedge mclk_i);
    end
  endtask

  task automatic pipe(input logic hold, input logic pr);
    begin
      @(posedge mclk_i);
      pipe_clk_o <= 1'b1;
      hold_o     <= hold;
      preset_o   <= pr;
      repeat (4) @(posedge mclk_i);
      pipe_clk_o <= 1'b0;
      hold_o     <= 1'b0;
      preset_o   <= 1'b0;
      repeat (4) @(posedge mclk_i);
    end
  endtask
endmodule // ram_port_user

// [verification/true_dual_port_block_ram_asserts.sv]
// Checker on the dual-port memory's output pins.
// Assumes port A in latch mode, port B piped, no cascade.
`timescale 1ns/1ps

module tdp_ram_checker (
  input wire logic        mclk_i,
  input wire logic        reset_i,
  input wire logic        port_a_clk_i,
  input wire logic        port_a_enable_i,
  input wire logic        port_a_pipe_clk_i,
  input wire logic        pipe_stage_hold_ctrl_a_i,
  input wire logic        output_sync_preset_a_i,
  input wire logic [31:0] read_word_bus_a_o,
  input wire logic [3:0]  read_check_bits_a_o,
  input wire logic        depth_link_out_unreg_a_o,
  input wire logic        depth_link_out_piped_a_o,
  input wire logic        port_b_pipe_clk_i,
  input wire logic        pipe_stage_hold_ctrl_b_i,
  input wire logic        output_sync_preset_b_i,
  input wire logic [31:0] read_word_bus_b_o,
  input wire logic [3:0]  read_check_bits_b_o,
  input wire logic        depth_link_out_unreg_b_o,
  input wire logic        depth_link_out_piped_b_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  // A change is traced back two samples, where the request was still held
  a_word_quiet_a:
    assert property (!$stable(read_word_bus_a_o) |-> $past(port_a_clk_i, 2)
      && $past(port_a_enable_i, 2)) else $error("port A word moved untimely");
  a_chk_quiet_a:
    assert property (!$stable(read_check_bits_a_o) |-> $past(port_a_clk_i, 2)
      && $past(port_a_enable_i, 2)) else $error("port A check bits moved untimely");
  b_word_piped_a:
    assert property (!$stable(read_word_bus_b_o) |-> $past(port_b_pipe_clk_i, 2)
      && $past(pipe_stage_hold_ctrl_b_i, 2)) else $error("port B word moved untimely");
  b_chk_piped_a:
    assert property (!$stable(read_check_bits_b_o) |-> $past(port_b_pipe_clk_i, 2)
      && $past(pipe_stage_hold_ctrl_b_i, 2)) else $error("port B check bits moved untimely");
  a_preset_zero_a:
    assert property ($past(output_sync_preset_a_i, 2) && !$stable(read_word_bus_a_o)
      |-> read_word_bus_a_o == 32'h0 && read_check_bits_a_o == 4'h0)
      else $error("port A preset value wrong");
  b_preset_zero_a:
    assert property ($past(output_sync_preset_b_i, 2) && !$stable(read_word_bus_b_o)
      |-> read_word_bus_b_o == 32'h0 && read_check_bits_b_o == 4'h0)
      else $error("port B preset value wrong");
  a_link_bit_a:
    assert property (depth_link_out_unreg_a_o == read_word_bus_a_o[0])
      else $error("port A cascade bit differs");
  b_link_bit_a:
    assert property (depth_link_out_piped_b_o == read_word_bus_b_o[0])
      else $error("port B cascade bit differs");
  // The pipe stage copies the latch as it stood just before its own tick
  b_link_pipe_a:
    assert property (!$stable(depth_link_out_piped_b_o) && !$past(output_sync_preset_b_i, 2)
      |-> depth_link_out_piped_b_o == $past(depth_link_out_unreg_b_o))
      else $error("port B pipe bit not copied from latch");
  a_pipe_hold_a:
    assert property (!$stable(depth_link_out_piped_a_o) |-> $past(port_a_pipe_clk_i, 2)
      && $past(pipe_stage_hold_ctrl_a_i, 2)) else $error("port A pipe bit moved untimely");

  cover property (!$stable(read_word_bus_a_o));
  cover property (!$stable(read_word_bus_b_o));
  cover property ($past(output_sync_preset_b_i, 2) && !$stable(read_word_bus_b_o));
endmodule // tdp_ram_checker

bind true_dual_port_block_ram tdp_ram_checker checker_u (
  .mclk_i(mclk_i), .reset_i(reset_i), .port_a_clk_i(port_a_clk_i),
  .port_a_enable_i(port_a_enable_i), .output_sync_preset_a_i(output_sync_preset_a_i),
  .port_a_pipe_clk_i(port_a_pipe_clk_i), .pipe_stage_hold_ctrl_a_i(pipe_stage_hold_ctrl_a_i),
  .depth_link_out_piped_a_o(depth_link_out_piped_a_o),
  .depth_link_out_unreg_b_o(depth_link_out_unreg_b_o),
  .read_word_bus_a_o(read_word_bus_a_o), .read_check_bits_a_o(read_check_bits_a_o),
  .depth_link_out_unreg_a_o(depth_link_out_unreg_a_o), .port_b_pipe_clk_i(port_b_pipe_clk_i),
  .pipe_stage_hold_ctrl_b_i(pipe_stage_hold_ctrl_b_i),
  .output_sync_preset_b_i(output_sync_preset_b_i), .read_word_bus_b_o(read_word_bus_b_o),
  .read_check_bits_b_o(read_check_bits_b_o), .depth_link_out_piped_b_o(depth_link_out_piped_b_o)
);

// [verification/true_dual_port_block_ram_tb.sv]
// Self-checking bench: A transparent latch, B old-data piped.
// Assumes the two port user models drive every port request.
`timescale 1ns/1ps
`include "dpram_defines.vh"

module true_dual_port_block_ram_tb;
  localparam [35:0] D0 = 36'h3C3C3C3C3;
  localparam [35:0] D1 = 36'hA13579BDF;
  localparam [35:0] D2 = 36'h52468ACE0;
  localparam [35:0] D3 = 36'h9FEDCBA98;
  localparam [35:0] D4 = 36'h60F0F0F0F;
  logic        mclk_i, reset_i;
  int          num_errors, cmp_count;
  wire         a_ck, a_pck, a_en, a_pre, a_hold, b_ck, b_pck, b_en, b_pre, b_hold;
  wire [3:0]   a_we, a_chk, a_rchk, b_we, b_chk, b_rchk;
  wire [12:0]  a_addr, b_addr;
  wire [31:0]  a_word, a_rword, b_word, b_rword;
  wire [35:0]  out_a = {a_rchk, a_rword};
  wire [35:0]  out_b = {b_rchk, b_rword};

  ram_port_user pa (.mclk_i(mclk_i), .clk_o(a_ck), .pipe_clk_o(a_pck), .en_o(a_en),
    .we_o(a_we), .addr_o(a_addr), .word_o(a_word), .chk_o(a_chk), .preset_o(a_pre),
    .hold_o(a_hold));
  ram_port_user pb (.mclk_i(mclk_i), .clk_o(b_ck), .pipe_clk_o(b_pck), .en_o(b_en),
    .we_o(b_we), .addr_o(b_addr), .word_o(b_word), .chk_o(b_chk), .preset_o(b_pre),
    .hold_o(b_hold));
  true_dual_port_block_ram #(.WMODE_B(`WMODE_OLD_DATA), .PIPED_B(1)) dut_u (
    .mclk_i(mclk_i), .reset_i(reset_i), .port_a_clk_i(a_ck), .port_a_pipe_clk_i(a_pck),
    .port_a_enable_i(a_en), .port_a_byte_we_i(a_we), .port_a_addr_i(a_addr),
    .write_word_bus_a_i(a_word), .write_check_bits_a_i(a_chk),
    .output_sync_preset_a_i(a_pre), .pipe_stage_hold_ctrl_a_i(a_hold),
    .depth_link_in_unreg_a_i(1'b0), .depth_link_in_piped_a_i(1'b0),
    .read_word_bus_a_o(a_rword), .read_check_bits_a_o(a_rchk),
    .depth_link_out_unreg_a_o(), .depth_link_out_piped_a_o(),
    .port_b_clk_i(b_ck), .port_b_pipe_clk_i(b_pck), .port_b_enable_i(b_en),
    .port_b_byte_we_i(b_we), .port_b_addr_i(b_addr), .write_word_bus_b_i(b_word),
    .write_check_bits_b_i(b_chk), .output_sync_preset_b_i(b_pre),
    .pipe_stage_hold_ctrl_b_i(b_hold), .depth_link_in_unreg_b_i(1'b0),
    .depth_link_in_piped_b_i(1'b0), .read_word_bus_b_o(b_rword),
    .read_check_bits_b_o(b_rchk), .depth_link_out_unreg_b_o(), .depth_link_out_piped_b_o());

  always #10 mclk_i = ~mclk_i;

  task automatic check36(input logic [35:0] exp, input logic [35:0] got);
    begin
      cmp_count++;
      if (got !== exp)
      begin
        num_errors++;
        $display("mismatch at %0t: expected %h got %h", $time, exp, got);
      end
    end
  endtask

  // Enabled bytes take the new byte and its check bit, the rest stay
  function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] nw,
                                        input logic [3:0] we);
    logic [35:0] m;
    begin
      m = {we, {8{we[3]}}, {8{we[2]}}, {8{we[1]}}, {8{we[0]}}};
      merge = (nw & m) | (old & ~m);
    end
  endfunction

  task automatic t_write_read;
    begin
      pa.access(1'b1, 4'hF, 13'h0010, D1, 1'b0);
      check36(D1, out_a);
      pa.pipe(1'b1, 1'b0);
      check36(D1, out_a);
      pa.access(1'b1, 4'h0, 13'h0010, D0, 1'b0);
      check36(D1, out_a);
      $display("test write_read done");
    end
  endtask

  task automatic t_old_data;
    begin
      pb.access(1'b1, 4'hF, 13'h0010, D2, 1'b0);
      check36(36'h0, out_b);
      pb.pipe(1'b1, 1'b0);
      check36(D1, out_b);
      pa.access(1'b1, 4'h0, 13'h0010, D0, 1'b0);
      check36(D2, out_a);
      pa.access(1'b0, 4'hF, 13'h0010, D3, 1'b0);
      check36(D2, out_a);
      pb.access(1'b1, 4'h0, 13'h0010, D0, 1'b0);
      pb.pipe(1'b1, 1'b0);
      check36(D2, out_b);
      $display("test old_data done");
    end
  endtask

  task automatic t_byte_write;
    begin
      pa.access(1'b1, 4'h3, 13'h0010, D3, 1'b0);
      check36(merge(D2, D3, 4'h3), out_a);
      $display("test byte_write done");
    end
  endtask

  task automatic t_collision;
    begin
      pa.access(1'b1, 4'hF, 13'h0020, D1, 1'b0);
      fork
        pb.access(1'b1, 4'hF, 13'h0020, D4, 1'b0);
        pa.access(1'b1, 4'h0, 13'h0020, D0, 1'b0);
      join
      check36(D1, out_a);
      pb.pipe(1'b1, 1'b0);
      check36(D1, out_b);
      pa.access(1'b1, 4'h0, 13'h0020, D0, 1'b0);
      check36(D4, out_a);
      $display("test collision done");
    end
  endtask

  task automatic t_preset;
    begin
      pa.access(1'b0, 4'h0, 13'h0020, D0, 1'b1);
      check36(D4, out_a);
      pa.access(1'b1, 4'h0, 13'h0020, D0, 1'b1);
      check36(36'h0, out_a);
      pb.access(1'b1, 4'h0, 13'h0010, D0, 1'b0);
      pb.pipe(1'b0, 1'b1);
      check36(D1, out_b);
      pb.pipe(1'b1, 1'b0);
      check36(merge(D2, D3, 4'h3), out_b);
      pb.pipe(1'b1, 1'b1);
      check36(36'h0, out_b);
      $display("test preset done");
    end
  endtask

  task automatic results;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  initial
  begin
    mclk_i = 1'b0;
    reset_i = 1'b1;
    repeat (4) @(posedge mclk_i);
    reset_i <= 1'b0;
    t_write_read();
    t_old_data();
    t_byte_write();
    t_collision();
    t_preset();
    results();
  end

  // About 20 frames of 9 mclk are expected; this allows about sixteen times that
  initial
  begin
    #60000;
    num_errors++;
    results();
  end
endmodule // true_dual_port_block_ram_tb

// [verilog/dpram_defines.vh]
// Constants shared by the dual-port memory and its output stage.
// Assumes inclusion by bare name from the design files and the bench.
`ifndef DPRAM_DEFINES_VH
`define DPRAM_DEFINES_VH

// ----------------------------------------------------------------
// Storage geometry
// ----------------------------------------------------------------
`define RAM_ADDR_W      12
`define RAM_DEPTH       4096
`define RAM_BYTE_W      9
`define RAM_MAX_BYTES   4
`define RAM_WORD_W      36

// ----------------------------------------------------------------
// Write modes
// ----------------------------------------------------------------
`define WMODE_TRANSPARENT 2'h0
`define WMODE_OLD_DATA    2'h1
`define WMODE_HOLD        2'h2

// ----------------------------------------------------------------
// Cascade roles, clock edge and enable polarity
// ----------------------------------------------------------------
`define CASC_NONE       2'h0
`define CASC_LOWER      2'h1
`define CASC_UPPER      2'h2
`define EDGE_RISE       1'b0
`define EDGE_FALL       1'b1
`define EN_ACT_HIGH     1'b0
`define EN_ACT_LOW      1'b1

// ----------------------------------------------------------------
// Output reset and preset values
// ----------------------------------------------------------------
`define OUT_INIT        36'h000000000
`define OUT_PRESET      36'h000000000

`endif

// [verilog/port_output_stage.v]
// Output latch and optional pipeline register of one memory port.
// Assumes one-cycle ticks from the port and pipe clock edge detectors.
`timescale 1ns/1ps

`include "dpram_defines.vh"

module port_output_stage #(
  parameter             PIPED  = 0,
  parameter [35:0]      INIT   = `OUT_INIT,
  parameter [35:0]      PRESET = `OUT_PRESET
) (
  input  wire           mclk_i,
  input  wire           reset_i,
  input  wire           acc_tick_i,
  input  wire           pipe_tick_i,
  input  wire           en_act_i,
  input  wire           load_i,
  input  wire [35:0]    load_word_i,
  input  wire           link_sel_i,
  input  wire           preset_i,
  input  wire           hold_ctrl_i,
  input  wire           link_lat_i,
  input  wire           link_pipe_i,
  output wire [35:0]    data_o,
  output wire           lat_bit_o,
  output wire           pipe_bit_o
);

  reg  [35:0] lat_r;
  reg  [35:0] pipe_r;
  reg         lsel_r;
  reg         lpend_r;
  reg         ppend_r;

  // ----------------------------------------------------------------
  // Latch and pipeline register
  // ----------------------------------------------------------------
  // A cascaded bit from the neighbour settles one clock after the load,
  // since the neighbour's latch updates on the same edge.
  always @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      lat_r   <= INIT;
      pipe_r  <= INIT;
      lsel_r  <= 1'b0;
      lpend_r <= 1'b0;
      ppend_r <= 1'b0;
    end
    else
    begin
      lpend_r <= 1'b0;
      ppend_r <= 1'b0;
      if (acc_tick_i && en_act_i)                        // R2
      begin
        if (preset_i && PIPED == 0)                      // R3
        begin
          lat_r  <= PRESET;                              // R26
          lsel_r <= 1'b0;
        end
        else if (load_i)                                 // R4
        begin
          lat_r   <= load_word_i;
          lsel_r  <= link_sel_i;
          lpend_r <= link_sel_i;
        end
      end
      if (lpend_r)
        lat_r[0] <= link_lat_i;                          // R21
      if (pipe_tick_i && hold_ctrl_i)                    // R18
      begin
        if (preset_i)                                    // R25
          pipe_r <= PRESET;                              // R26
        else
        begin
          pipe_r  <= lat_r;                              // R5
          ppend_r <= lsel_r;
        end
      end
      if (ppend_r)
        pipe_r[0] <= link_pipe_i;                        // R21
    end
  end

  assign data_o     = (PIPED != 0) ? pipe_r : lat_r;
  assign lat_bit_o  = lat_r[0];
  assign pipe_bit_o = pipe_r[0];

endmodule // port_output_stage

// [verilog/true_dual_port_block_ram.v]
// True dual-port memory: one byte array (9-bit bytes) and two ports.
// Assumes user logic on mclk_i drives all port inputs except the port
// and pipe clock pins, which arrive asynchronously and are sampled.
//
// Operation
// R1: One array shared by two symmetric ports
// R2: Disabled port writes nothing, output holds
// R3: Sync preset acts in latch and piped modes
// R4: Latch read: one edge, address then data
// R5: Pipe register adds one cycle read latency
// R6: Write completes on one active edge
// R7: Per-port write mode, transparent by default
// R8: Transparent: written data appears on output
// R9: Old-data: output shows word before write
// R10: Hold: output unchanged by writes
// R11: Simple dual-port forces old-data write mode
// R12: No arbitration; user avoids same-address conflicts
// R13: Async clocks: no access during other's write
// R14: Async read-during-write still stores valid data
// R15: Common clock: no differing same-address writes
// R16: Old-data writer: other port reads old word
// R17: Other writer modes: other port read invalid
// R18: Pipe register has own clock and enable
// R19: Read and write widths set per port
// R20: Mixed widths: new written bytes, old others
// R21: Cascade pins, unregistered and piped pairs
// R22: Check bits usable as extra data bits
// R23: Clock edge selectable, rising by default
// R24: Enable polarity selectable, high by default
// R25: Piped preset needs hold control asserted
// R26: Preset loads configured value into output
`timescale 1ns/1ps

`include "dpram_defines.vh"

module true_dual_port_block_ram #(
  parameter [1:0]       WMODE_A     = `WMODE_TRANSPARENT,
  parameter [1:0]       WMODE_B     = `WMODE_TRANSPARENT,
  parameter             SIMPLE_DP   = 0,
  parameter             RD_BYTES_A  = 4,
  parameter             WR_BYTES_A  = 4,
  parameter             RD_BYTES_B  = 4,
  parameter             WR_BYTES_B  = 4,
  parameter             PIPED_A     = 0,
  parameter             PIPED_B     = 0,
  parameter [0:0]       EDGE_A      = `EDGE_RISE,
  parameter [0:0]       EDGE_B      = `EDGE_RISE,
  parameter [0:0]       EN_POL_A    = `EN_ACT_HIGH,
  parameter [0:0]       EN_POL_B    = `EN_ACT_HIGH,
  parameter [1:0]       CASCADE     = `CASC_NONE,
  parameter [35:0]      INIT_A      = `OUT_INIT,
  parameter [35:0]      INIT_B      = `OUT_INIT,
  parameter [35:0]      PRESET_A    = `OUT_PRESET,
  parameter [35:0]      PRESET_B    = `OUT_PRESET
) (
  input  wire           mclk_i,
  input  wire           reset_i,
  input  wire           port_a_clk_i,
  input  wire           port_a_pipe_clk_i,
  input  wire           port_a_enable_i,
  input  wire [3:0]     port_a_byte_we_i,
  input  wire [12:0]    port_a_addr_i,
  input  wire [31:0]    write_word_bus_a_i,
  input  wire [3:0]     write_check_bits_a_i,
  input  wire           output_sync_preset_a_i,
  input  wire           pipe_stage_hold_ctrl_a_i,
  input  wire           depth_link_in_unreg_a_i,
  input  wire           depth_link_in_piped_a_i,
  output wire [31:0]    read_word_bus_a_o,
  output wire [3:0]     read_check_bits_a_o,
  output wire           depth_link_out_unreg_a_o,
  output wire           depth_link_out_piped_a_o,
  input  wire           port_b_clk_i,
  input  wire           port_b_pipe_clk_i,
  input  wire           port_b_enable_i,
  input  wire [3:0]     port_b_byte_we_i,
  input  wire [12:0]    port_b_addr_i,
  input  wire [31:0]    write_word_bus_b_i,
  input  wire [3:0]     write_check_bits_b_i,
  input  wire           output_sync_preset_b_i,
  input  wire           pipe_stage_hold_ctrl_b_i,
  input  wire           depth_link_in_unreg_b_i,
  input  wire           depth_link_in_piped_b_i,
  output wire [31:0]    read_word_bus_b_o,
  output wire [3:0]     read_check_bits_b_o,
  output wire           depth_link_out_unreg_b_o,
  output wire           depth_link_out_piped_b_o
);

  localparam AW = `RAM_ADDR_W;
  localparam BW = `RAM_BYTE_W;

  // ----------------------------------------------------------------
  // Shared storage and per-port packing
  // ----------------------------------------------------------------
  reg  [BW-1:0] mem [0:`RAM_DEPTH-1];                    // R1

  wire [1:0]    clk_pin  = {port_b_clk_i, port_a_clk_i};
  wire [1:0]    pipe_pin = {port_b_pipe_clk_i, port_a_pipe_clk_i};
  wire [1:0]    en_pin   = {port_b_enable_i, port_a_enable_i};
  wire [1:0]    preset   = {output_sync_preset_b_i, output_sync_preset_a_i};
  wire [1:0]    hold     = {pipe_stage_hold_ctrl_b_i, pipe_stage_hold_ctrl_a_i};
  wire [1:0]    lnk_lat  = {depth_link_in_unreg_b_i, depth_link_in_unreg_a_i};
  wire [1:0]    lnk_pipe = {depth_link_in_piped_b_i, depth_link_in_piped_a_i};
  wire [7:0]    we_pk    = {port_b_byte_we_i, port_a_byte_we_i};
  wire [25:0]   addr_pk  = {port_b_addr_i, port_a_addr_i};
  wire [63:0]   word_pk  = {write_word_bus_b_i, write_word_bus_a_i};
  wire [7:0]    chk_pk   = {write_check_bits_b_i, write_check_bits_a_i};

  wire [71:0]   din_pk;
  wire [7:0]    wr_en_pk;
  wire [95:0]   wr_adr_pk;
  wire [71:0]   rd_out_pk;
  wire [1:0]    lat_bit;
  wire [1:0]    pipe_bit;

  // ----------------------------------------------------------------
  // Per-port logic
  // ----------------------------------------------------------------
  genvar p;
  genvar j;
  generate
    for (p = 0; p < 2; p = p + 1)
    begin : g_port
      localparam [1:0] WM = (SIMPLE_DP != 0) ? `WMODE_OLD_DATA :    // R11
                            ((p == 0) ? WMODE_A : WMODE_B);       // R7
      localparam integer RB = (p == 0) ? RD_BYTES_A : RD_BYTES_B; // R19
      localparam integer WB = (p == 0) ? WR_BYTES_A : WR_BYTES_B;
      localparam [0:0] EDG = (p == 0) ? EDGE_A : EDGE_B;
      localparam [0:0] ENP = (p == 0) ? EN_POL_A : EN_POL_B;
      localparam [AW-1:0] RMASK = RB[AW-1:0] - 1'b1;
      localparam [AW-1:0] WMASK = WB[AW-1:0] - 1'b1;

      // Pin clocks: the first stage feeds only the second
      reg  [2:0] cs_r;
      reg  [2:0] ps_r;
      always @(posedge mclk_i or posedge reset_i)
      begin
        if (reset_i)
        begin
          cs_r <= 3'h0;
          ps_r <= 3'h0;
        end
        else
        begin
          cs_r <= {cs_r[1:0], clk_pin[p]};
          ps_r <= {ps_r[1:0], pipe_pin[p]};
        end
      end

      wire tick = (EDG == `EDGE_RISE) ? (cs_r[1] & ~cs_r[2]) :   // R23
                                        (~cs_r[1] & cs_r[2]);
      wire ptick = (EDG == `EDGE_RISE) ? (ps_r[1] & ~ps_r[2]) :
                                         (~ps_r[1] & ps_r[2]);
      wire en_act = en_pin[p] ^ ENP;                             // R24

      wire [12:0]   adr = addr_pk[p*13 +: 13];
      wire          own = (CASCADE == `CASC_NONE) ? 1'b1 :
                          (CASCADE == `CASC_UPPER) ? adr[12] : ~adr[12];
      wire [AW-1:0] ra  = adr[AW-1:0] & ~RMASK;
      wire [AW-1:0] wa  = adr[AW-1:0] & ~WMASK;
      wire [3:0]    we_eff;
      wire          wr_go = tick & en_act & own & (|we_eff);     // R2

      for (j = 0; j < 4; j = j + 1)
      begin : g_wbyte
        localparam [AW-1:0] JOFF = j;
        assign we_eff[j] = (j < WB) ? we_pk[p*4+j] : 1'b0;
        assign din_pk[(p*4+j)*BW +: BW] =                        // R22
          {chk_pk[p*4+j], word_pk[p*32+j*8 +: 8]};
        assign wr_en_pk[p*4+j] = wr_go & we_eff[j];
        assign wr_adr_pk[(p*4+j)*AW +: AW] = wa + JOFF;
      end

      // Read word as stored before this edge; the other port's write on
      // the same edge is not forwarded, so its data is old data only.
      reg  [35:0]   rword;
      reg  [AW-1:0] rk;
      reg  [1:0]    jk;
      integer       k;
      always @*
      begin
        rword = 36'h000000000;
        rk    = {AW{1'b0}};
        jk    = 2'h0;
        for (k = 0; k < 4; k = k + 1)
        begin
          rk = ra + k[AW-1:0];
          jk = rk[1:0] & WMASK[1:0];
          if (k < RB)
          begin
            rword[k*BW +: BW] = mem[rk];                         // R16 R17
            if (WM == `WMODE_TRANSPARENT && wr_go &&             // R8
                ((rk & ~WMASK) == wa) && we_eff[jk])
              rword[k*BW +: BW] = din_pk[(p*4+jk)*BW +: BW];     // R20
          end
        end
      end

      // Hold mode leaves the output alone on any write edge. Ownership gates
      // writes only: an upper half must still load to take the neighbour's bit.
      wire load = tick & !(WM == `WMODE_HOLD && wr_go);          // R10 R9
      wire lsel = (CASCADE == `CASC_UPPER) & ~adr[12];           // R21

      port_output_stage #(
        .PIPED   ((p == 0) ? PIPED_A : PIPED_B),
        .INIT    ((p == 0) ? INIT_A : INIT_B),
        .PRESET  ((p == 0) ? PRESET_A : PRESET_B)
      ) u_out (
        .mclk_i      (mclk_i),
        .reset_i     (reset_i),
        .acc_tick_i  (tick),
        .pipe_tick_i (ptick),
        .en_act_i    (en_act),
        .load_i      (load),
        .load_word_i (rword),
        .link_sel_i  (lsel),
        .preset_i    (preset[p]),
        .hold_ctrl_i (hold[p]),
        .link_lat_i  (lnk_lat[p]),
        .link_pipe_i (lnk_pipe[p]),
        .data_o      (rd_out_pk[p*36 +: 36]),
        .lat_bit_o   (lat_bit[p]),
        .pipe_bit_o  (pipe_bit[p])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Array writes
  // ----------------------------------------------------------------
  // Port B is applied after port A, so B wins a same-edge clash; the
  // user keeps such clashes away, this order only makes them defined.
  integer i;
  always @(posedge mclk_i)
  begin
    for (i = 0; i < 8; i = i + 1)
      if (wr_en_pk[i])                                   // R6 R14 R12
        mem[wr_adr_pk[i*AW +: AW]] <= din_pk[i*BW +: BW];
  end

  // ----------------------------------------------------------------
  // Output mapping
  // ----------------------------------------------------------------
  generate
    for (j = 0; j < 4; j = j + 1)
    begin : g_obyte
      assign read_word_bus_a_o[j*8 +: 8] = rd_out_pk[j*BW +: 8];
      assign read_check_bits_a_o[j]      = rd_out_pk[j*BW + 8];  // R22
      assign read_word_bus_b_o[j*8 +: 8] = rd_out_pk[36 + j*BW +: 8];
      assign read_check_bits_b_o[j]      = rd_out_pk[36 + j*BW + 8];
    end
  endgenerate

  assign depth_link_out_unreg_a_o = lat_bit[0];
  assign depth_link_out_piped_a_o = pipe_bit[0];
  assign depth_link_out_unreg_b_o = lat_bit[1];
  assign depth_link_out_piped_b_o = pipe_bit[1];

endmodule // true_dual_port_block_ram
